// File: ccu_access_filter_regs.sv
// Access-control and address-filter registers of the coherence unit.
// Assumes AHB-Lite single word transfers and a writer sideband valid in the address phase.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module ccu_access_filter_regs
  import ccu_pkg::*;
(
  input  wire logic                 clk_in,               // Unit clock, 10 MHz
  input  wire logic                 reset_n_in,           // Async reset, active low
  input  wire logic                 hsel_in,              // AHB slave select
  input  wire logic [31:0]          haddr_in,             // AHB address
  input  wire logic [1:0]           htrans_in,            // AHB transfer type
  input  wire logic                 hwrite_in,            // AHB write
  input  wire logic [2:0]           hsize_in,             // AHB size
  input  wire logic [31:0]          hwdata_in,            // AHB write data
  input  wire logic                 hready_in,            // AHB bus ready
  input  wire ccu_pkg::ccu_writer_t writer_in,            // Issuing core and security
  output logic [31:0]               hrdata_out,           // AHB read data
  output logic                      hreadyout_out,        // AHB slave ready
  output logic                      hresp_out,            // AHB response
  input  wire logic [1:0]           num_cores_m1_in,      // Cores present minus one
  input  wire logic                 two_master_ports_in,  // Second master port present
  input  wire logic [11:0]          reset_filter_start_pins_in, // Filter start default
  input  wire logic [11:0]          reset_filter_end_pins_in,   // Filter end default
  input  wire logic [31:0]          route_addr_in,        // Transaction address to steer
  output logic                      route_to_port1_out,   // Address goes to master port 1
  output logic [3:0]                tag_invalidate_out    // Per-core tag clear pulse
);
  import ccu_pkg::*;

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic                 wr_pend_r;
  logic                 rd_pend_r;
  ccu_reg_sel_t         sel_r;
  ccu_writer_t          writer_r;
  logic                 boot_done_r;
  logic [11:0]          filt_start_r;
  logic [11:0]          filt_end_r;
  logic [3:0]           wr_permit_r;
  logic [3:0]           ns_permit_r;
  logic [3:0]           inv_pulse_r;
  logic [31:0]          hrdata_r;
  logic [3:0]           present;
  logic                 accept;
  logic                 permit_ok;
  ccu_reg_sel_t         sel_nxt;

  assign accept = hsel_in && hready_in && (htrans_in == CCU_HTRANS_NONSEQ) && (hsize_in == CCU_HSIZE_WORD);

  always_comb begin
    unique case (haddr_in[7:0])
      CCU_OFS_INVAL_ALL:  sel_nxt = CCU_REG_INV;
      CCU_OFS_FILT_START: sel_nxt = CCU_REG_FSTART;
      CCU_OFS_FILT_END:   sel_nxt = CCU_REG_FEND;
      CCU_OFS_WR_PERMIT:  sel_nxt = CCU_REG_WPERM;
      CCU_OFS_NS_PERMIT:  sel_nxt = CCU_REG_NSPERM;
      CCU_OFS_BANK_CFG:   sel_nxt = CCU_REG_CFG;
      default:            sel_nxt = CCU_REG_NONE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      sel_r     <= CCU_REG_NONE;
      writer_r  <= '0;
    end else begin
      wr_pend_r <= accept && hwrite_in;
      rd_pend_r <= accept && !hwrite_in;
      if (accept) begin
        sel_r    <= sel_nxt;
        writer_r <= writer_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write permission
  // ----------------------------------------------------------------
  // Cores above the present count are treated as absent
  always_comb begin
    for (int i = 0; i < CCU_NUM_CORES; i++) begin
      present[i] = (2'(i) <= num_cores_m1_in);
    end
  end

  // Secure needs the permit bit; non-secure also needs its own bit
  assign permit_ok = wr_permit_r[writer_r.core_id] &&
                     (!writer_r.nonsecure || ns_permit_r[writer_r.core_id]);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_permit_r <= CCU_WR_PERMIT_RST;
    end else if (wr_pend_r && permit_ok && sel_r == CCU_REG_WPERM) begin
      // Once all bits are cleared, no core can write again until reset, so zero is a lock
      wr_permit_r <= hwdata_in[3:0];
    end
  end

  // Non-secure permit is Secure-only writable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ns_permit_r <= CCU_NS_PERMIT_RST;
    end else if (wr_pend_r && permit_ok && !writer_r.nonsecure && sel_r == CCU_REG_NSPERM) begin
      ns_permit_r <= hwdata_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Tag invalidate command
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inv_pulse_r <= 4'h0;
    end else begin
      for (int i = 0; i < CCU_NUM_CORES; i++) begin
        inv_pulse_r[i] <= wr_pend_r && sel_r == CCU_REG_INV && permit_ok && !writer_r.nonsecure &&
                          present[i] &&
                          hwdata_in[i*CCU_INV_FIELD_W +: CCU_INV_FIELD_W] == CCU_INV_TRIGGER;
      end
    end
  end
  assign tag_invalidate_out = inv_pulse_r;

  // ----------------------------------------------------------------
  // Filter range
  // ----------------------------------------------------------------
  // Pins are caught on the first clock after release, never under reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_done_r  <= 1'b0;
      filt_start_r <= '0;
      filt_end_r   <= '0;
    end else if (!boot_done_r) begin
      boot_done_r  <= 1'b1;
      filt_start_r <= reset_filter_start_pins_in;
      filt_end_r   <= reset_filter_end_pins_in;
    end else if (wr_pend_r && permit_ok && two_master_ports_in) begin
      if (sel_r == CCU_REG_FSTART) begin
        filt_start_r <= hwdata_in[CCU_FILT_LSB +: CCU_FILT_W];
      end
      if (sel_r == CCU_REG_FEND) begin
        filt_end_r <= hwdata_in[CCU_FILT_LSB +: CCU_FILT_W];
      end
    end
  end

  // Inclusive end; end below start leaves the window empty
  assign route_to_port1_out = two_master_ports_in && boot_done_r &&
                              route_addr_in[CCU_FILT_LSB +: CCU_FILT_W] >= filt_start_r &&
                              route_addr_in[CCU_FILT_LSB +: CCU_FILT_W] <= filt_end_r;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Loaded in the address phase for zero wait states; a read right
  // behind a write to the same register returns the value before it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_r <= CCU_ZERO_WORD;
    end else if (accept && !hwrite_in) begin
      hrdata_r <= CCU_ZERO_WORD;
      unique case (sel_nxt)
        CCU_REG_FSTART: if (two_master_ports_in) hrdata_r[CCU_FILT_LSB +: CCU_FILT_W] <= filt_start_r;
        CCU_REG_FEND:   if (two_master_ports_in) hrdata_r[CCU_FILT_LSB +: CCU_FILT_W] <= filt_end_r;
        CCU_REG_WPERM:  hrdata_r[3:0] <= wr_permit_r;
        CCU_REG_NSPERM: hrdata_r[3:0] <= ns_permit_r;
        CCU_REG_CFG:    hrdata_r[2:0] <= {two_master_ports_in, num_cores_m1_in};
        CCU_REG_INV, CCU_REG_NONE: hrdata_r <= CCU_ZERO_WORD;
      endcase
    end
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_inv_needs_ones;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[0] |-> $past(hwdata_in[3:0]) == CCU_INV_TRIGGER;
  endproperty
  a_inv_needs_ones: assert property (p_inv_needs_ones) else $error("invalidate without 1111");

  property p_inv_absent;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[3] |-> $past(num_cores_m1_in) == 2'h3;
  endproperty
  a_inv_absent: assert property (p_inv_absent) else $error("absent core invalidated");

  property p_inv_secure;
    @(posedge clk_in) disable iff (!reset_n_in)
      (|tag_invalidate_out) |-> !$past(writer_r.nonsecure) && $past(permit_ok);
  endproperty
  a_inv_secure: assert property (p_inv_secure) else $error("invalidate not secure or permitted");

  property p_empty_window;
    @(posedge clk_in) disable iff (!reset_n_in)
      (filt_end_r < filt_start_r) |-> !route_to_port1_out;
  endproperty
  a_empty_window: assert property (p_empty_window) else $error("route with end below start");

  property p_equal_window;
    @(posedge clk_in) disable iff (!reset_n_in)
      (boot_done_r && two_master_ports_in && filt_end_r == filt_start_r &&
       route_addr_in[CCU_FILT_LSB +: CCU_FILT_W] == filt_end_r) |-> route_to_port1_out;
  endproperty
  a_equal_window: assert property (p_equal_window) else $error("equal window not routed");

  property p_start_sample;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(boot_done_r) |-> filt_start_r == $past(reset_filter_start_pins_in) &&
                              filt_end_r == $past(reset_filter_end_pins_in);
  endproperty
  a_start_sample: assert property (p_start_sample) else $error("filter pins not sampled");

  property p_single_port;
    @(posedge clk_in) disable iff (!reset_n_in)
      (boot_done_r && $past(boot_done_r) && !two_master_ports_in && !$past(two_master_ports_in)) |->
        $stable(filt_start_r) && $stable(filt_end_r);
  endproperty
  a_single_port: assert property (p_single_port) else $error("filter written in single port");

  property p_dropped;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && !permit_ok) |=> $stable(wr_permit_r) && $stable(ns_permit_r);
  endproperty
  a_dropped: assert property (p_dropped) else $error("unpermitted write took effect");

  property p_lock;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_permit_r == 4'h0) |=> wr_permit_r == 4'h0 ##1 wr_permit_r == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("locked permit changed");

  // ----------------------------------------------------------------
  // Checks on the remaining fields and on read data
  // ----------------------------------------------------------------
  property p_inv_ones_c1;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[1] |-> $past(hwdata_in[CCU_INV_FIELD_W +: CCU_INV_FIELD_W]) == CCU_INV_TRIGGER;
  endproperty
  a_inv_ones_c1: assert property (p_inv_ones_c1) else $error("core 1 invalidate without 1111");

  property p_inv_ones_c2;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[2] |-> $past(hwdata_in[2*CCU_INV_FIELD_W +: CCU_INV_FIELD_W]) == CCU_INV_TRIGGER;
  endproperty
  a_inv_ones_c2: assert property (p_inv_ones_c2) else $error("core 2 invalidate without 1111");

  property p_inv_ones_c3;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[3] |-> $past(hwdata_in[3*CCU_INV_FIELD_W +: CCU_INV_FIELD_W]) == CCU_INV_TRIGGER;
  endproperty
  a_inv_ones_c3: assert property (p_inv_ones_c3) else $error("core 3 invalidate without 1111");

  property p_inv_absent_c2;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[2] |-> $past(num_cores_m1_in) >= 2'h2;
  endproperty
  a_inv_absent_c2: assert property (p_inv_absent_c2) else $error("absent core 2 invalidated");

  property p_inv_absent_c1;
    @(posedge clk_in) disable iff (!reset_n_in)
      tag_invalidate_out[1] |-> $past(num_cores_m1_in) >= 2'h1;
  endproperty
  a_inv_absent_c1: assert property (p_inv_absent_c1) else $error("absent core 1 invalidated");

  property p_inv_dropped;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && !permit_ok) |=> tag_invalidate_out == 4'h0;
  endproperty
  a_inv_dropped: assert property (p_inv_dropped) else $error("invalidate from unpermitted write");

  property p_ns_secure_only;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && writer_r.nonsecure) |=> $stable(ns_permit_r);
  endproperty
  a_ns_secure_only: assert property (p_ns_secure_only) else $error("non-secure write changed ns permit");

  property p_filt_dropped;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && !permit_ok) |=> $stable(filt_start_r) && $stable(filt_end_r);
  endproperty
  a_filt_dropped: assert property (p_filt_dropped) else $error("unpermitted filter write landed");

  property p_wperm_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && permit_ok && sel_r == CCU_REG_WPERM) |=> wr_permit_r == $past(hwdata_in[CCU_NUM_CORES-1:0]);
  endproperty
  a_wperm_write: assert property (p_wperm_write) else $error("permitted permit write lost");

  property p_fstart_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_pend_r && permit_ok && two_master_ports_in && sel_r == CCU_REG_FSTART) |=>
        filt_start_r == $past(hwdata_in[CCU_FILT_LSB +: CCU_FILT_W]);
  endproperty
  a_fstart_write: assert property (p_fstart_write) else $error("permitted start write lost");

  property p_single_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      (rd_pend_r && (sel_r == CCU_REG_FSTART || sel_r == CCU_REG_FEND) && !$past(two_master_ports_in)) |->
        hrdata_out == CCU_ZERO_WORD;
  endproperty
  a_single_read: assert property (p_single_read) else $error("filter read not zero in single port");

  property p_reserved_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      rd_pend_r |-> hrdata_out[CCU_FILT_LSB-1:CCU_NUM_CORES] == '0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero");

  property p_route_bounds;
    @(posedge clk_in) disable iff (!reset_n_in)
      route_to_port1_out |-> two_master_ports_in && filt_start_r <= filt_end_r;
  endproperty
  a_route_bounds: assert property (p_route_bounds) else $error("route with empty window");

  property p_permit_reset;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(boot_done_r) |-> wr_permit_r == CCU_WR_PERMIT_RST && ns_permit_r == CCU_NS_PERMIT_RST;
  endproperty
  a_permit_reset: assert property (p_permit_reset) else $error("permit bits wrong after reset");

  c_invalidate: cover property (@(posedge clk_in) disable iff (!reset_n_in) |tag_invalidate_out);
  c_lock:       cover property (@(posedge clk_in) disable iff (!reset_n_in) wr_permit_r == 4'h0);
  c_route:      cover property (@(posedge clk_in) disable iff (!reset_n_in) route_to_port1_out);
  c_equal:      cover property (@(posedge clk_in) disable iff (!reset_n_in)
                                route_to_port1_out && filt_start_r == filt_end_r);

endmodule : ccu_access_filter_regs

// File: ccu_core_bfm.sv
// Bus master model of the cores that reach the access and filter register bank.
// Assumes one clock and an AHB-Lite slave; a hung wait is reported through tb.bus_hung.
`timescale 1ns/1ps

module ccu_core_bfm
  import ccu_pkg::*;
(
  input  wire logic            clk_in,     // Unit clock
  input  wire logic [31:0]     hrdata_in,  // Read data
  input  wire logic            hready_in,  // Bus ready
  output logic                 hsel_out,   // Slave select
  output logic [31:0]          haddr_out,  // Address
  output logic [1:0]           htrans_out, // Transfer type
  output logic                 hwrite_out, // Write
  output logic [2:0]           hsize_out,  // Size
  output logic [31:0]          hwdata_out, // Write data
  output ccu_pkg::ccu_writer_t writer_out  // Issuing core and security
);
  import ccu_pkg::*;
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = CCU_HSIZE_WORD;
    hwdata_out = 32'h0;
    writer_out = '0;
  end

  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 50);
    if (n >= 50) tb.bus_hung();
  endtask : wait_ready

  // No cache is modelled, so no shared lines exist at an invalidate
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input ccu_writer_t wr, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_out   <= 1'b1;
    htrans_out <= CCU_HTRANS_NONSEQ;
    haddr_out  <= {24'h0, a};
    hwrite_out <= w;
    writer_out <= wr;
    wait_ready();
    htrans_out <= 2'h0;
    hsel_out   <= 1'b0;
    hwdata_out <= d;
    wait_ready();
    rd = hrdata_in;
    // Released data lines must not keep the old value
    hwdata_out <= ~d;
  endtask : xfer
endmodule : ccu_core_bfm

// File: ccu_pkg.sv
// Package for the coherence unit access and filter register bank.
// Assumes a 32-bit AHB-Lite register bus and up to four cores.
package ccu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CCU_OFS_INVAL_ALL   = 8'h00;
  localparam logic [7:0] CCU_OFS_FILT_START  = 8'h04;
  localparam logic [7:0] CCU_OFS_FILT_END    = 8'h08;
  localparam logic [7:0] CCU_OFS_WR_PERMIT   = 8'h0c;
  localparam logic [7:0] CCU_OFS_NS_PERMIT   = 8'h10;
  localparam logic [7:0] CCU_OFS_BANK_CFG    = 8'h14;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         CCU_NUM_CORES       = 4;
  localparam int         CCU_INV_FIELD_W     = 4;
  localparam logic [3:0] CCU_INV_TRIGGER     = 4'hf;
  localparam int         CCU_FILT_LSB        = 20;
  localparam int         CCU_FILT_W          = 12;
  localparam logic [3:0] CCU_WR_PERMIT_RST   = 4'hf;
  localparam logic [3:0] CCU_NS_PERMIT_RST   = 4'h0;
  localparam logic [1:0] CCU_HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0] CCU_HSIZE_WORD      = 3'h2;
  localparam logic [31:0] CCU_ZERO_WORD      = 32'h0000_0000;

  // Sideband that travels with each register write
  typedef struct packed {
    logic [1:0] core_id;
    logic       nonsecure;
  } ccu_writer_t;

  typedef enum logic [2:0] {
    CCU_REG_INV, CCU_REG_FSTART, CCU_REG_FEND, CCU_REG_WPERM, CCU_REG_NSPERM, CCU_REG_CFG, CCU_REG_NONE
  } ccu_reg_sel_t;

endpackage : ccu_pkg

// File: tb.sv
// Self-checking bench for the access and filter register bank, against an integer model.
// Assumes ccu_core_bfm as the only bus master and a 10 MHz unit clock.
`timescale 1ns/1ps

module tb;
  import ccu_pkg::*;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic        clk_in, reset_n_in, hsel, hwrite, hready, hresp, two_ports, route;
  logic [31:0] haddr, hwdata, hrdata, route_addr;
  logic [1:0]  htrans, ncm1;
  logic [2:0]  hsize;
  logic [11:0] fs_pins, fe_pins;
  logic [3:0]  inv;
  ccu_writer_t wr, wrd;
  int          bad_count, checks, seed, perm, nsp, fs, fe;

  ccu_access_filter_regs i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .writer_in(wr), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .num_cores_m1_in(ncm1),
    .two_master_ports_in(two_ports), .reset_filter_start_pins_in(fs_pins), .reset_filter_end_pins_in(fe_pins),
    .route_addr_in(route_addr), .route_to_port1_out(route), .tag_invalidate_out(inv));
  ccu_core_bfm u_core (.clk_in(clk_in), .hrdata_in(hrdata), .hready_in(hready), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata),
    .writer_out(wr));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic bus_hung;
    bad_count++;
    tally_and_finish();
  endtask : bus_hung

  function automatic logic [31:0] mread(input int sel);
    case (sel)
      1: return two_ports ? 32'(fs) << 20 : 32'h0;
      2: return two_ports ? 32'(fe) << 20 : 32'h0;
      3: return 32'(perm);
      4: return 32'(nsp);
      5: return {29'h0, two_ports, ncm1};
      default: return 32'h0;
    endcase
  endfunction : mread

  task automatic rchk(input logic [31:0] a);
    @(posedge clk_in);
    route_addr <= a;
    @(negedge clk_in);
    chk({31'h0, route}, {31'h0, 1'(two_ports && fs <= a[31:20] && a[31:20] <= fe)});
  endtask : rchk

  task automatic op(input int sel, input int c, input int ns, input logic [31:0] d);
    logic [31:0] rd;
    logic [3:0]  exp;
    logic [31:0] ra[5];
    ccu_writer_t w;
    w = '{core_id: 2'(c), nonsecure: ns[0]};
    exp = 4'h0;
    u_core.xfer(1'b1, 8'(sel * 4), d, w, rd);
    case (sel)
      0: for (int i = 0; i < 4; i++) exp[i] = !ns && perm[c] && i <= ncm1 && d[4*i+:4] == CCU_INV_TRIGGER;
      1: if (perm[c] && (!ns || nsp[c]) && two_ports) fs = d[31:20];
      2: if (perm[c] && (!ns || nsp[c]) && two_ports) fe = d[31:20];
      3: if (perm[c] && (!ns || nsp[c])) perm = d[3:0];
      4: if (!ns && perm[c]) nsp = d[3:0];
      default: ;
    endcase
    @(negedge clk_in);
    chk({28'h0, inv}, {28'h0, exp});
    chk({31'h0, hresp}, 32'h0);
    @(negedge clk_in);
    chk({28'h0, inv}, 32'h0);
    u_core.xfer(1'b0, 8'(sel * 4), 32'h0, w, rd);
    chk(rd, mread(sel));
    ra = '{32'(fs) << 20, (32'(fe) << 20) | 32'hfffff, 32'((fe + 1) & 'hfff) << 20,
           32'((fs - 1) & 'hfff) << 20, $random(seed)};
    foreach (ra[k]) rchk(ra[k]);
  endtask : op

  task automatic boot_reads;
    logic [31:0] rd;
    perm = 15;
    nsp = 0;
    fs = fs_pins;
    fe = fe_pins;
    for (int s = 0; s < 7; s++) begin
      u_core.xfer(1'b0, 8'(s * 4), 32'h0, wrd, rd);
      chk(rd, mread(s));
    end
    rchk({fs_pins, 20'h0});
    rchk({fe_pins, 20'hfffff});
  endtask : boot_reads

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d, r;
    seed = 77432;
    reset_n_in = 1'b0;
    two_ports = 1'b1;
    ncm1 = 2'h1;
    route_addr = 32'h0;
    wrd = '0;
    fs_pins = 12'($random(seed));
    fe_pins = 12'($random(seed));
    bad_count = 0;
    checks = 0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    boot_reads();
    op(1, 0, 0, 32'h0010_0000);
    op(2, 1, 0, 32'h001f_ffff);
    op(1, 0, 0, 32'h0020_0000);
    op(2, 1, 0, 32'hfff0_0000);
    op(4, 0, 0, 32'hffff_fff5);
    op(1, 0, 1, 32'h0030_0000);
    op(1, 1, 1, 32'h0040_0000);
    for (int i = 0; i < 160; i++) begin
      if (i % 25 == 0 || i == 100) begin
        @(posedge clk_in);
        ncm1 <= 2'($random(seed));
        if (i == 100) two_ports <= 1'b0;
      end
      // Lock attempt from every core; only the first permitted one lands
      if (i == 130) for (int c = 0; c < 4; c++) op(3, c, 0, 32'h0);
      r = $random(seed);
      d = $random(seed);
      d[15:0] = d[15:0] | {{4{r[3]}}, {4{r[2]}}, {4{r[1]}}, {4{r[0]}}};
      if ({r[31:9]} % 7 == 3) d[r[5:4]] = 1'b1;
      op({r[31:9]} % 7, r[8:7], r[6], d);
    end
    // Second reset with new pin levels; it also lifts the lock
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    two_ports  <= 1'b1;
    fs_pins    <= 12'($random(seed));
    fe_pins    <= 12'($random(seed));
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    chk(hrdata | {27'h0, inv, route}, 32'h0);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    boot_reads();
    op(0, 1, 0, 32'h0000_ffff);
    tally_and_finish();
  end
endmodule : tb
